//--- common/slot_sample_timer_consts.svh
// Constants for the slot and sample timer
`ifndef SLOT_SAMPLE_TIMER_CONSTS_SVH
`define SLOT_SAMPLE_TIMER_CONSTS_SVH

// Register offsets
`define SST_ADDR_GEN_RESET 8'h01
`define SST_ADDR_CLK_SEL 8'h02
`define SST_ADDR_CTRL 8'h10
`define SST_ADDR_LIVE 8'h11
`define SST_ADDR_SLEEP 8'h12
`define SST_ADDR_WAKE 8'h13
`define SST_ADDR_CAPTURE 8'h14
`define SST_ADDR_SLOT_ADJ 8'h15
`define SST_ADDR_SAMPLE_ADJ 8'h16
`define SST_ADDR_TRIGGER 8'h17
`define SST_ADDR_MAX_AUTO 8'h18

// Reset values and field positions
`define SST_CTRL_RESET 8'h80
`define SST_CTRL_PIN_BIT 7
`define SST_CTRL_SLEEP_BIT 2
`define SST_CTRL_MODE_LSB 0
`define SST_CTRL_MODE_MSB 1
`define SST_CLK_SEL_MSB 3
`define SST_SLOT_LSB 16
`define SST_SLOT_MSB 27
`define SST_SAMPLE_MSB 10

// Counter ranges
`define SST_SAMPLE_LAST 11'h4ff
`define SST_SLOT_LAST 12'h8c9
`define SST_SLOTS_PER_FRAME 2250

// Tracking window
`define SST_TRACK_LO 11'h140
`define SST_TRACK_HI 11'h3c0
`define SST_TRACK_MID 16'h0280

// Reference clock steps
`define SST_REF_STEP_HZ 2400000
`define SST_SAMPLE_HZ 48000
`define SST_REF_STEP_DIV (`SST_REF_STEP_HZ / `SST_SAMPLE_HZ)
`define SST_MULT_MAX 4'ha

`endif

//--- common/slot_sample_timer_pkg.sv
// Types for the slot and sample timer
package slot_sample_timer_pkg;

	typedef enum logic [1:0] {
		NUDGE_MANUAL = 2'b00,
		NUDGE_ACQUIRE = 2'b01,
		NUDGE_TRACK = 2'b10,
		NUDGE_RESERVED = 2'b11
	} nudge_mode_t;

	typedef struct packed {
		logic [8:0] edges;
		logic ref_prev;
		logic tick;
	} tick_state_t;

	typedef struct packed {
		logic [3:0] clock_sel;
		logic pin_open_drain;
		logic sleep_enable;
		nudge_mode_t mode;
		logic [10:0] sample;
		logic [11:0] slot;
		logic [10:0] sleep_point;
		logic [10:0] wake_point;
		logic [31:0] capture;
		logic [15:0] slot_adjust;
		logic [15:0] sample_adjust;
		logic [10:0] trigger;
		logic [10:0] max_auto;
		logic manual_pending;
		logic auto_pending;
		logic [15:0] auto_value;
		logic pps_prev;
		logic pulse_out;
		logic pulse_oe;
		logic ch1_asleep;
		logic ch2_asleep;
		logic done;
		logic [31:0] rdata;
		logic rvalid;
	} timer_state_t;

endpackage : slot_sample_timer_pkg

//--- hw/sample_tick_gen.sv
// Sample rate tick derived from the reference clock
`timescale 1ns/1ps
`default_nettype none
`include "slot_sample_timer_consts.svh"

module sample_tick_gen (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic ref_in,
	input wire logic [3:0] mult,
	output logic tick
);

	slot_sample_timer_pkg::tick_state_t s;
	slot_sample_timer_pkg::tick_state_t next_s;
	logic [8:0] divisor;

	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		next_s.ref_prev = ref_in;
		divisor = 9'(mult * `SST_REF_STEP_DIV);
		if (mult == 4'h0 || mult > `SST_MULT_MAX) begin
			next_s.edges = 9'h000;
		end else if (ref_in && !s.ref_prev) begin
			if (s.edges >= divisor - 9'h001) begin
				next_s.edges = 9'h000;
				next_s.tick = 1'b1;
			end else begin
				next_s.edges = s.edges + 9'h001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign tick = s.tick;

endmodule : sample_tick_gen

`default_nettype wire

//--- hw/slot_sample_timer.sv
// Slot and sample timer with nudge, capture, slot pulse and sleep control
`timescale 1ns/1ps
`default_nettype none
`include "slot_sample_timer_consts.svh"

// Function
// R1: Clock select cleared only by pin reset
// R2: Code zero stops clocks; 1-10 pick reference
// R3: Host avoids codes 11-15 and upper bits
// R4: Counters run at 48 kHz from reference
// R5: Sample counter 0 to 1279 then wraps
// R6: Slot counter steps on sample wrap, 0-2249
// R7: Live word: slot 27-16, sample 10-0
// R8: Slot pulse low during first sample
// R9: Control bit 7 selects open-drain pin drive
// R10: Counters free run after reset; after pin reset they hold at zero until clock select is set nonzero
// R11: Control bit 2 enables receiver sleep
// R12: Receivers sleep during inactive slots
// R13: Sleep at sleep point in inactive slot
// R14: Wake at wakeup point after inactive slot
// R15: Mode bits: manual, acquire, track
// R16: Pulse edge captures both counters
// R17: Signed slot adjust added at trigger
// R18: Auto modes use second pulse reference
// R19: Sample adjust write arms both adjustments
// R20: Manual apply signals done, clears adjustments
// R21: Apply when sample equals trigger value
// R22: Track value from count, clamped to maximum
// R23: Reserved bits ignored, read as zero
// R24: Counters and words clear on reset
module slot_sample_timer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic reference_clock_in,
	input wire logic second_pulse_in,
	input wire logic receive_channel_one_busy,
	input wire logic receive_channel_two_busy,
	output logic slot_pulse_out,
	output logic slot_pulse_oe,
	output logic receive_channel_one_asleep,
	output logic receive_channel_two_asleep,
	output logic nudge_done
);

	slot_sample_timer_pkg::timer_state_t s;
	slot_sample_timer_pkg::timer_state_t next_s;
	logic tick;
	logic running;
	logic at_trigger;
	logic pps_edge;
	logic gen_reset;
	logic wr_sample_adj;
	logic pulse_active;
	logic [10:0] inc_sample;
	logic [11:0] inc_slot;
	logic [3:0] keep_sel;
	logic [3:0] tick_mult;

	// Counter word layout shared by live and capture reads
	function automatic logic [31:0] count_word(input logic [11:0] slot, input logic [10:0] sample);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`SST_SLOT_MSB:`SST_SLOT_LSB] = slot;
		w[`SST_SAMPLE_MSB:0] = sample;
		return w;
	endfunction : count_word

	// Slot plus signed adjustment, wrapped into the frame
	function automatic logic [11:0] wrap_slot(input logic [11:0] slot, input logic [15:0] adj);
		int t;
		t = int'(slot) + int'($signed(adj));
		t = t % `SST_SLOTS_PER_FRAME;
		if (t < 0) begin
			t = t + `SST_SLOTS_PER_FRAME;
		end
		return t[11:0];
	endfunction : wrap_slot

	// Tracking correction from the count at the pulse edge
	function automatic logic [15:0] track_value(input logic [10:0] cnt, input logic [10:0] lim);
		logic signed [15:0] v;
		logic signed [15:0] m;
		m = $signed({5'h00, lim});
		if (cnt >= `SST_TRACK_LO && cnt < `SST_TRACK_HI) begin
			v = $signed(`SST_TRACK_MID - {5'h00, cnt}); // R22
		end else begin
			v = $signed(16'h0000 - {5'h00, cnt}); // R22
		end
		if (v > m) begin
			v = m; // R22
		end else if (v < -m) begin
			v = -m; // R22
		end
		return v;
	endfunction : track_value

	sample_tick_gen u_tick (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.ref_in(reference_clock_in),
		.mult(tick_mult),
		.tick(tick)
	);

	// General reset restarts the sample period
	assign tick_mult = gen_reset ? 4'h0 : s.clock_sel; // R8
	assign running = (s.clock_sel != 4'h0); // R2
	assign pps_edge = second_pulse_in && !s.pps_prev;
	assign at_trigger = tick && running && (s.sample == s.trigger); // R21
	assign wr_sample_adj = reg_wr && (reg_addr == `SST_ADDR_SAMPLE_ADJ);

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		next_s.rvalid = 1'b0;
		next_s.pps_prev = second_pulse_in;
		gen_reset = 1'b0;
		keep_sel = 4'h0;
		inc_sample = s.sample;
		inc_slot = s.slot;

		// Free running counters at the sample rate
		if (tick && running) begin // R4 R10
			if (s.sample == `SST_SAMPLE_LAST) begin
				inc_sample = 11'h000; // R5
				if (s.slot == `SST_SLOT_LAST) begin
					inc_slot = 12'h000; // R6
				end else begin
					inc_slot = s.slot + 12'h001; // R6
				end
			end else begin
				inc_sample = s.sample + 11'h001; // R5
			end
		end
		next_s.sample = inc_sample;
		next_s.slot = inc_slot;

		// Adjustments at the trigger point
		if (at_trigger) begin
			case (s.mode) // R15
				slot_sample_timer_pkg::NUDGE_MANUAL: begin
					if (s.manual_pending) begin
						next_s.sample = 11'(inc_sample + s.sample_adjust[10:0]); // R19
						next_s.slot = wrap_slot(inc_slot, s.slot_adjust); // R17
						next_s.slot_adjust = 16'h0000; // R20
						next_s.sample_adjust = 16'h0000; // R20
						next_s.manual_pending = 1'b0;
						next_s.done = 1'b1; // R20
					end
				end
				slot_sample_timer_pkg::NUDGE_ACQUIRE: begin
					if (s.auto_pending) begin
						next_s.sample = 11'(inc_sample + s.auto_value[10:0]); // R18
						next_s.auto_pending = 1'b0;
						next_s.done = 1'b1;
					end
				end
				slot_sample_timer_pkg::NUDGE_TRACK: begin
					if (s.auto_pending) begin
						next_s.sample = 11'(inc_sample + s.auto_value[10:0]); // R18
						next_s.auto_pending = 1'b0;
						if (s.slot_adjust != 16'h0000) begin
							next_s.slot = wrap_slot(inc_slot, s.slot_adjust); // R17
							next_s.slot_adjust = 16'h0000;
							next_s.done = 1'b1;
						end
					end
				end
				default: begin
					next_s.auto_pending = 1'b0;
				end
			endcase
		end

		// Second pulse edge: capture and auto correction
		if (pps_edge) begin
			next_s.capture = count_word(s.slot, s.sample); // R16
			case (s.mode)
				slot_sample_timer_pkg::NUDGE_ACQUIRE: begin
					next_s.auto_value = 16'h0000 - {5'h00, s.sample}; // R18
					next_s.auto_pending = 1'b1;
				end
				slot_sample_timer_pkg::NUDGE_TRACK: begin
					next_s.auto_value = track_value(s.sample, s.max_auto); // R22
					next_s.auto_pending = 1'b1;
				end
				default: begin
					next_s.auto_pending = s.auto_pending;
				end
			endcase
		end

		// Receiver sleep control
		if (!s.sleep_enable) begin // R11
			next_s.ch1_asleep = 1'b0;
			next_s.ch2_asleep = 1'b0;
		end else begin
			if (s.sample == s.sleep_point) begin // R12 R13
				if (!receive_channel_one_busy) begin
					next_s.ch1_asleep = 1'b1;
				end
				if (!receive_channel_two_busy) begin
					next_s.ch2_asleep = 1'b1;
				end
			end
			if (s.sample == s.wake_point) begin // R14
				next_s.ch1_asleep = 1'b0;
				next_s.ch2_asleep = 1'b0;
			end
		end

		// Register writes; new values win over auto clears
		if (reg_wr) begin
			case (reg_addr)
				`SST_ADDR_GEN_RESET: begin
					gen_reset = 1'b1;
				end
				`SST_ADDR_CLK_SEL: begin
					next_s.clock_sel = reg_wdata[`SST_CLK_SEL_MSB:0]; // R1 R23
					gen_reset = (reg_wdata[`SST_CLK_SEL_MSB:0] == 4'h0);
				end
				`SST_ADDR_CTRL: begin
					next_s.pin_open_drain = reg_wdata[`SST_CTRL_PIN_BIT]; // R9
					next_s.sleep_enable = reg_wdata[`SST_CTRL_SLEEP_BIT]; // R11
					next_s.mode = slot_sample_timer_pkg::nudge_mode_t'(
						reg_wdata[`SST_CTRL_MODE_MSB:`SST_CTRL_MODE_LSB]); // R15
				end
				`SST_ADDR_SLEEP: begin
					next_s.sleep_point = reg_wdata[`SST_SAMPLE_MSB:0]; // R23
				end
				`SST_ADDR_WAKE: begin
					next_s.wake_point = reg_wdata[`SST_SAMPLE_MSB:0]; // R23
				end
				`SST_ADDR_SLOT_ADJ: begin
					next_s.slot_adjust = reg_wdata;
				end
				`SST_ADDR_SAMPLE_ADJ: begin
					next_s.sample_adjust = reg_wdata;
				end
				`SST_ADDR_TRIGGER: begin
					next_s.trigger = reg_wdata[`SST_SAMPLE_MSB:0]; // R23
				end
				`SST_ADDR_MAX_AUTO: begin
					next_s.max_auto = reg_wdata[`SST_SAMPLE_MSB:0]; // R23
				end
				default: begin
					next_s.clock_sel = next_s.clock_sel;
				end
			endcase
		end
		if (wr_sample_adj && s.mode == slot_sample_timer_pkg::NUDGE_MANUAL) begin
			next_s.manual_pending = 1'b1; // R19
		end

		// Register reads, answered one cycle later
		if (reg_rd) begin
			next_s.rvalid = 1'b1;
			case (reg_addr)
				`SST_ADDR_LIVE: next_s.rdata = count_word(s.slot, s.sample); // R7 R23
				`SST_ADDR_CAPTURE: next_s.rdata = s.capture; // R16 R23
				default: next_s.rdata = 32'h0000_0000;
			endcase
		end

		// General reset spares the clock select
		if (gen_reset) begin
			keep_sel = next_s.clock_sel;
			next_s = '0; // R24
			next_s.pin_open_drain = 1'(`SST_CTRL_RESET >> `SST_CTRL_PIN_BIT);
			next_s.clock_sel = keep_sel; // R1
			next_s.pps_prev = second_pulse_in;
		end

		// Slot pulse pin drive
		pulse_active = (next_s.clock_sel != 4'h0) && (next_s.sample == 11'h000); // R8
		if (next_s.pin_open_drain) begin
			next_s.pulse_out = 1'b0; // R9
			next_s.pulse_oe = pulse_active; // R9
		end else begin
			next_s.pulse_out = !pulse_active; // R8 R9
			next_s.pulse_oe = 1'b1; // R9
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0; // R1 R24
			s.pin_open_drain <= 1'(`SST_CTRL_RESET >> `SST_CTRL_PIN_BIT);
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.rdata;
	assign reg_rvalid = s.rvalid;
	assign slot_pulse_out = s.pulse_out;
	assign slot_pulse_oe = s.pulse_oe;
	assign receive_channel_one_asleep = s.ch1_asleep;
	assign receive_channel_two_asleep = s.ch2_asleep;
	assign nudge_done = s.done;

endmodule : slot_sample_timer

`default_nettype wire

//--- tb/slot_sample_timer_chk.sv
// Port checker for the slot and sample timer
`timescale 1ns/1ps
`default_nettype none
module slot_sample_timer_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic receive_channel_one_busy,
	input wire logic receive_channel_two_busy,
	input wire logic slot_pulse_out,
	input wire logic slot_pulse_oe,
	input wire logic receive_channel_one_asleep,
	input wire logic receive_channel_two_asleep,
	input wire logic nudge_done
);
	wire act = slot_pulse_oe && !slot_pulse_out;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence rd_taken;
		ce && reg_rd;
	endsequence
	sequence cnt_read;
		reg_rvalid && ($past(reg_addr) == 8'h11 || $past(reg_addr) == 8'h14);
	endsequence
	chk_read_answer: assert property (rd_taken |=> reg_rvalid)
		else $error("Read got no answer");
	chk_no_stray: assert property (!(ce && reg_rd) |=> !reg_rvalid)
		else $error("Answer without read");
	chk_count_reserved: assert property (cnt_read |-> reg_rdata[31:28] == 4'h0 && reg_rdata[15:11] == 5'h00)
		else $error("Reserved count bits set");
	chk_count_range: assert property (cnt_read |-> reg_rdata[10:0] <= 11'h4ff && reg_rdata[27:16] <= 12'h8c9)
		else $error("Count out of range");
	chk_wo_zero: assert property (reg_rvalid && $past(reg_addr) == 8'h10 |-> reg_rdata == 32'h0)
		else $error("Write-only read not zero");
	chk_done_single: assert property (nudge_done |=> !nudge_done)
		else $error("Done longer than a cycle");
	chk_sleep_one: assert property ($rose(receive_channel_one_asleep) |-> !$past(receive_channel_one_busy))
		else $error("Busy channel one slept");
	chk_sleep_two: assert property ($rose(receive_channel_two_asleep) |-> !$past(receive_channel_two_busy))
		else $error("Busy channel two slept");
	chk_release_low: assert property (!slot_pulse_oe |-> !slot_pulse_out)
		else $error("Released pin value high");
	chk_pulse_width: assert property ($rose(act) |-> act [*8])
		else $error("Slot pulse too short");
	chk_reset_quiet: assert property ($rose(rst_n) |-> !reg_rvalid && !nudge_done && !slot_pulse_oe)
		else $error("Outputs active after reset");
endmodule : slot_sample_timer_chk
bind slot_sample_timer slot_sample_timer_chk slot_sample_timer_chk_inst (
	.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.receive_channel_one_busy(receive_channel_one_busy),
	.receive_channel_two_busy(receive_channel_two_busy),
	.slot_pulse_out(slot_pulse_out), .slot_pulse_oe(slot_pulse_oe),
	.receive_channel_one_asleep(receive_channel_one_asleep),
	.receive_channel_two_asleep(receive_channel_two_asleep), .nudge_done(nudge_done)
);
`default_nettype wire

//--- tb/host_model.sv
// Host model driving the register bus
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [15:0] reg_wdata,
	output logic reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 16'h0000;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= (a == 8'h02) ? {12'h000, d[3:0]} : d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		q = reg_rvalid ? reg_rdata : 'x;
	endtask : rd
endmodule : host_model
`default_nettype wire

//--- tb/tb.sv
// Testbench for the slot and sample timer
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, rst_n, ce, ref_in, ref_run, sp, busy1, busy2;
	logic reg_wr, reg_rd, reg_rvalid, pout, poe, sl1, sl2, done;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [31:0] reg_rdata, v, w;
	int fail_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int i;
	host_model host_model_inst (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
	slot_sample_timer slot_sample_timer_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reference_clock_in(ref_in),
		.second_pulse_in(sp), .receive_channel_one_busy(busy1),
		.receive_channel_two_busy(busy2), .slot_pulse_out(pout), .slot_pulse_oe(poe),
		.receive_channel_one_asleep(sl1), .receive_channel_two_asleep(sl2),
		.nudge_done(done));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (ref_run) ref_in <= ~ref_in;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count++;
			wrap_up;
		end
	end
	task automatic wrap_up;
		if (fail_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		host_model_inst.wr(a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		host_model_inst.rd(a, v);
	endtask : rd
	task automatic run(input int n);
		ref_run <= 1'b1;
		repeat (n) @(posedge clk);
		ref_run <= 1'b0;
	endtask : run
	task automatic run_done;
		i = 0;
		ref_run <= 1'b1;
		while (done !== 1'b1 && i < 3000) begin
			@(posedge clk);
			i++;
		end
		ref_run <= 1'b0;
		chk(32'(done), 32'h1);
	endtask : run_done
	task automatic pulse;
		sp <= 1'b1;
		repeat (3) @(posedge clk);
		sp <= 1'b0;
	endtask : pulse
	task automatic s_reset;
		rd(8'h11);
		chk(v, 32'h0);
		rd(8'h14);
		chk(v, 32'h0);
		rd(8'h10);
		chk(v, 32'h0);
		run(400);
		rd(8'h11);
		chk(v, 32'h0);
		chk(32'(poe), 32'h0);
	endtask : s_reset
	task automatic s_nudge;
		wr(8'h02, 16'h0001);
		run(400);
		rd(8'h11);
		chk(32'(v[10:0] != 11'h0 && v[27:16] == 12'h0), 32'h1);
		wr(8'h17, 16'(v[10:0] + 11'd2));
		wr(8'h15, 16'hffff);
		wr(8'h16, 16'(11'd1267 - v[10:0]));
		run_done;
		rd(8'h11);
		chk(v, {4'h0, 12'h8c9, 5'h00, 11'd1270});
	endtask : s_nudge
	task automatic s_wrap;
		i = 0;
		ref_run <= 1'b1;
		while (poe !== 1'b1 && i < 2000) begin
			@(posedge clk);
			i++;
		end
		chk(32'(pout), 32'h0);
		i = 0;
		while (poe === 1'b1 && i < 300) begin
			@(posedge clk);
			i++;
		end
		ref_run <= 1'b0;
		chk(i, 100);
		rd(8'h11);
		chk(v, 32'h1);
		wr(8'h10, 16'h0000);
		repeat (2) @(posedge clk);
		chk(32'({poe, pout}), 32'h3);
	endtask : s_wrap
	task automatic s_capture;
		rd(8'h11);
		w = v;
		pulse;
		rd(8'h14);
		chk(v, w);
	endtask : s_capture
	task automatic s_sleep;
		wr(8'h12, 16'h0001);
		repeat (3) @(posedge clk);
		chk(32'({sl1, sl2}), 32'h0);
		wr(8'h10, 16'h0004);
		repeat (3) @(posedge clk);
		chk(32'({sl1, sl2}), 32'h2);
		wr(8'h13, 16'h0001);
		repeat (3) @(posedge clk);
		chk(32'({sl1, sl2}), 32'h0);
	endtask : s_sleep
	task automatic s_auto;
		wr(8'h10, 16'h0001);
		wr(8'h17, 16'h0004);
		pulse;
		run_done;
		rd(8'h11);
		chk(v, 32'h4);
		wr(8'h10, 16'h0002);
		wr(8'h18, 16'h0003);
		wr(8'h17, 16'h0006);
		wr(8'h15, 16'h0001);
		pulse;
		run_done;
		rd(8'h11);
		chk(v, 32'h0001_0004);
	endtask : s_auto
	task automatic s_freeze;
		rd(8'h11);
		w = v;
		ce <= 1'b0;
		run(400);
		ce <= 1'b1;
		rd(8'h11);
		chk(v, w);
	endtask : s_freeze
	task automatic s_resets;
		wr(8'h01, 16'h0000);
		rd(8'h11);
		chk(v, 32'h0);
		run(400);
		rd(8'h11);
		chk(32'(v[10:0] != 11'h0), 32'h1);
		wr(8'h02, 16'h0000);
		run(400);
		rd(8'h11);
		chk(v, 32'h0);
	endtask : s_resets
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		ref_in = 1'b0;
		ref_run = 1'b0;
		sp = 1'b0;
		busy1 = 1'b0;
		busy2 = 1'b1;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		s_reset;
		s_nudge;
		s_wrap;
		s_capture;
		s_sleep;
		s_auto;
		s_freeze;
		s_resets;
		wrap_up;
	end
endmodule : tb
`default_nettype wire
